//--- verilog/slrg_pkg.sv
// Package for the strap latch and reset glue block
`default_nettype none
package slrg_pkg;
  localparam int          CLK_MHZ           = 250;
  // Delay windows in milliseconds
  localparam int          RSM_MIN_MS        = 200;
  localparam int          RSM_MAX_MS        = 300;
  localparam int          PWR_MIN_MS        = 300;
  localparam int          PWR_MAX_MS        = 500;
  // Aim midway in each window
  localparam int          RSM_DLY_MS        = (RSM_MIN_MS + RSM_MAX_MS) / 2;
  localparam int          PWR_DLY_MS        = (PWR_MIN_MS + PWR_MAX_MS) / 2;
  localparam int          RSM_DLY_CYC       = RSM_DLY_MS * 1000 * CLK_MHZ;
  localparam int          PWR_DLY_CYC       = PWR_DLY_MS * 1000 * CLK_MHZ;
  localparam int          CNT_W             = 27;
  // Configuration port pairs
  localparam logic [7:0]  CFG_INDEX_HI      = 8'h4E;
  localparam logic [7:0]  CFG_DATA_HI       = 8'h4F;
  localparam logic [7:0]  CFG_INDEX_LO      = 8'h2E;
  localparam logic [7:0]  CFG_DATA_LO       = 8'h2F;
  localparam int          CLK_RATE_HI_MHZ   = 48;
  localparam int          CLK_RATE_LO_MHZ   = 24;
  localparam int          NSTRAP            = 3;
  localparam int          STRAP_PORT        = 0;
  localparam int          STRAP_CLK         = 1;
  localparam int          STRAP_SEQ         = 2;
  localparam logic [NSTRAP-1:0] STRAP_RST   = 3'h0;
endpackage : slrg_pkg
`default_nettype wire

//--- verilog/slrg_strap_cell.sv
// One strap latch: captures on reset release, host override afterwards
`timescale 1ns/100ps
`default_nettype none
module slrg_strap_cell (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic cap_rst_n,
  input  wire logic strap_pin,
  input  wire logic wr_en,
  input  wire logic wr_val,
  output logic      value
);
  typedef struct packed {
    logic val;
    logic prev_rst_n;
  } slrg_cell_t;
  slrg_cell_t st_reg, st_next;

  always_comb begin
    st_next            = st_reg;
    st_next.prev_rst_n = cap_rst_n;
    if (!cap_rst_n) begin
      // Follow the pin while held so the release edge keeps the pin level
      st_next.val = strap_pin;
    end else if (wr_en) begin
      st_next.val = wr_val;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign value = st_reg.val;

  AST_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cap_rst_n && st_reg.prev_rst_n && !$past(wr_en)) |-> $stable(value))
    else $error("strap value changed without reset or override");
endmodule : slrg_strap_cell
`default_nettype wire

//--- verilog/slrg_top.sv
// Strap capture and power reset glue top
// Contract
// - Port select high 4E/4F, low 2E/2F
// - Clock strap high 48MHz, low 24MHz
// - Sequence strap enables function, standby reset
// - Standby straps writable, restored on standby reset
// - Main straps writable, restored by power good; the factory test strap is only latched, with no host write
// - Port strap on bus reset, writable, restored
// - Main pull-downs only during main power-up reset
// - Sequence pull-down only during standby power-up
// - Standby valid, wait t1, raise resume reset
// - Standby invalid drops resume reset immediately
// - Main power good only with main rail
// - Supply power good gates main power good
// - Resume reset delay 200 to 300 ms
// - Power good delay 300 to 500 ms
`timescale 1ns/100ps
`default_nettype none
module slrg_top
  import slrg_pkg::*;
#(
  parameter int RSM_CYC = slrg_pkg::RSM_DLY_CYC,
  parameter int PWR_CYC = slrg_pkg::PWR_DLY_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       standby_rail_valid,
  input  wire logic       main_rail_valid,
  input  wire logic       supply_power_good_in,
  input  wire logic       supply_pg_disable,
  input  wire logic       bus_reset_n,
  input  wire logic       cfg_port_select_strap,
  input  wire logic       input_clock_rate_strap,
  input  wire logic       power_sequence_enable_strap,
  input  wire logic       factory_test_strap,
  input  wire logic [2:0] host_wr_en,
  input  wire logic [2:0] host_wr_val,
  output logic            standby_resume_reset_n,
  output logic            main_power_good,
  output logic            main_pulldown_en,
  output logic            seq_pulldown_en,
  output logic [7:0]      cfg_index_port,
  output logic [7:0]      cfg_data_port,
  output logic            clock_is_48mhz,
  output logic [5:0]      input_clock_mhz,
  output logic            power_sequence_en,
  output logic            test_mode
);
  import slrg_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] rsm_cnt;
    logic [CNT_W-1:0] pwr_cnt;
    logic             rsm_n;
    logic             pwr_ok;
    logic             pd_main;
    logic             pd_seq;
    logic [7:0]       idx;
    logic [7:0]       dat;
    logic             clk48;
    logic [5:0]       clk_mhz;
    logic             seq_en;
    logic             test;
  } slrg_state_t;
  slrg_state_t st_reg, st_next;

  logic [NSTRAP-1:0] cap_rst_n;
  logic [NSTRAP-1:0] pins;
  logic [NSTRAP-1:0] strap_val;
  logic              main_ok;

  // Supply power good path is on unless disabled; default enabled
  // power good term
  assign main_ok = main_rail_valid && (supply_power_good_in || supply_pg_disable);

  assign cap_rst_n[STRAP_PORT] = bus_reset_n;
  assign cap_rst_n[STRAP_CLK]  = st_reg.pwr_ok;
  assign cap_rst_n[STRAP_SEQ]  = st_reg.rsm_n;
  assign pins[STRAP_PORT]      = cfg_port_select_strap;
  assign pins[STRAP_CLK]       = input_clock_rate_strap;
  assign pins[STRAP_SEQ]       = power_sequence_enable_strap;

  for (genvar i = 0; i < NSTRAP; i++) begin : g_strap
    slrg_strap_cell u_cell (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .cap_rst_n (cap_rst_n[i]),
      .strap_pin (pins[i]),
      .wr_en     (host_wr_en[i]),
      .wr_val    (host_wr_val[i]),
      .value     (strap_val[i])
    );
  end

  always_comb begin
    st_next = st_reg;
    if (!standby_rail_valid) begin
      st_next.rsm_cnt = '0;
      st_next.rsm_n   = 1'b0;
    end else if (!st_reg.rsm_n) begin
      if (st_reg.rsm_cnt >= CNT_W'(RSM_CYC - 1)) begin
        st_next.rsm_n = 1'b1;
      end else begin
        st_next.rsm_cnt = st_reg.rsm_cnt + 1'b1;
      end
    end
    if (!main_ok) begin
      st_next.pwr_cnt = '0;
      st_next.pwr_ok  = 1'b0;
    end else if (!st_reg.pwr_ok) begin
      if (st_reg.pwr_cnt >= CNT_W'(PWR_CYC - 1)) begin
        st_next.pwr_ok = 1'b1;
      end else begin
        st_next.pwr_cnt = st_reg.pwr_cnt + 1'b1;
      end
    end
    st_next.pd_main = !st_next.pwr_ok;
    st_next.pd_seq  = !st_next.rsm_n;
    st_next.idx = strap_val[STRAP_PORT] ? CFG_INDEX_HI : CFG_INDEX_LO;
    st_next.dat = strap_val[STRAP_PORT] ? CFG_DATA_HI : CFG_DATA_LO;
    st_next.clk48   = strap_val[STRAP_CLK];
    st_next.clk_mhz = strap_val[STRAP_CLK] ? 6'(CLK_RATE_HI_MHZ) : 6'(CLK_RATE_LO_MHZ);
    st_next.seq_en = strap_val[STRAP_SEQ];
    st_next.test = st_reg.pwr_ok ? st_reg.test : factory_test_strap;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg         <= '0;
      st_reg.pd_main <= 1'b1;
      st_reg.pd_seq  <= 1'b1;
      st_reg.idx     <= CFG_INDEX_LO;
      st_reg.dat     <= CFG_DATA_LO;
      st_reg.clk_mhz <= 6'(CLK_RATE_LO_MHZ);
    end else begin
      st_reg <= st_next;
    end
  end

  assign standby_resume_reset_n = st_reg.rsm_n;
  assign main_power_good        = st_reg.pwr_ok;
  assign main_pulldown_en       = st_reg.pd_main;
  assign seq_pulldown_en        = st_reg.pd_seq;
  assign cfg_index_port         = st_reg.idx;
  assign cfg_data_port          = st_reg.dat;
  assign clock_is_48mhz         = st_reg.clk48;
  assign input_clock_mhz        = st_reg.clk_mhz;
  assign power_sequence_en      = st_reg.seq_en;
  assign test_mode              = st_reg.test;

  sequence s_sb_lost;
    !standby_rail_valid;
  endsequence

  AST_RSM_DROP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_sb_lost |=> !standby_resume_reset_n)
    else $error("resume reset not dropped at once");

  AST_RSM_EARLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(standby_resume_reset_n) |-> st_reg.rsm_cnt == CNT_W'(RSM_CYC - 1))
    else $error("resume reset released at wrong count");

  AST_RSM_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(standby_resume_reset_n) |-> $past(standby_rail_valid))
    else $error("resume reset rose without standby rail");

  AST_PG_RAIL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !main_rail_valid |=> !main_power_good)
    else $error("power good without main rail");

  AST_PG_TERM: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!supply_power_good_in && !supply_pg_disable) |=> !main_power_good)
    else $error("power good ignored supply term");

  AST_PG_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(main_power_good) |-> st_reg.pwr_cnt == CNT_W'(PWR_CYC - 1))
    else $error("power good at wrong count");

  AST_PD_MAIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    main_pulldown_en == !main_power_good)
    else $error("main pull-down wrong");

  AST_PD_SEQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seq_pulldown_en == !standby_resume_reset_n)
    else $error("sequence pull-down wrong");

  AST_PORT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 cfg_index_port == ($past(strap_val[STRAP_PORT]) ? CFG_INDEX_HI : CFG_INDEX_LO))
    else $error("port pair mismatch");

  AST_CLK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 clock_is_48mhz == $past(strap_val[STRAP_CLK]))
    else $error("clock rate mismatch");

  AST_SEQ_RESTORE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !standby_resume_reset_n |-> ##2 power_sequence_en == $past(power_sequence_enable_strap, 2))
    else $error("sequence strap not restored");

  // Still counting towards release of the resume reset
  sequence s_sb_counting;
    standby_rail_valid && !standby_resume_reset_n && (st_reg.rsm_cnt < CNT_W'(RSM_CYC - 1));
  endsequence

  AST_RSM_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_sb_counting |=> !standby_resume_reset_n)
    else $error("resume reset released before delay");

  // Still counting towards main power good
  sequence s_pg_counting;
    main_ok && !main_power_good && (st_reg.pwr_cnt < CNT_W'(PWR_CYC - 1));
  endsequence

  AST_PG_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pg_counting |=> !main_power_good)
    else $error("power good raised before delay");

  AST_DATA_PORT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 cfg_data_port == ($past(strap_val[STRAP_PORT]) ? CFG_DATA_HI : CFG_DATA_LO))
    else $error("data port mismatch");

  AST_TEST_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(main_power_good) |-> $stable(test_mode))
    else $error("test strap changed while power good");
endmodule : slrg_top
`default_nettype wire

//--- verif/slrg_board_model.sv
// Board side of the strap pins: fitted resistors or the device pull-downs
`timescale 1ns/100ps
`default_nettype none
module slrg_board_model (
  input  wire logic       sys_clk,
  input  wire logic       main_pulldown_en,
  input  wire logic       seq_pulldown_en,
  input  wire logic [3:0] fit,
  input  wire logic [3:0] val,
  output logic      [3:0] pins
);
  logic       flip = 1'b0;
  logic [3:0] pd;
  always @(posedge sys_clk) flip <= ~flip;
  assign pd = {main_pulldown_en, seq_pulldown_en, main_pulldown_en, main_pulldown_en};
  // An open pin with no pull-down floats, so it toggles rather than holding
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pins[i] = fit[i] ? val[i] : (pd[i] ? 1'b0 : flip);
    end
  end
endmodule : slrg_board_model
`default_nettype wire

//--- verif/strap_latch_reset_glue_tb_top.sv
// Self-checking bench for strap capture and power reset glue
`timescale 1ns/100ps
`default_nettype none
module strap_latch_reset_glue_tb_top;
  import slrg_pkg::*;
  localparam int RSM = 20;
  localparam int PWR = 30;
  logic       sys_clk = 1'b0, rst_n = 1'b0, sb_ok = 1'b0, mn_ok = 1'b0;
  logic       spg = 1'b0, spg_dis = 1'b0, brst_n = 1'b0;
  logic [2:0] wen = 3'h0, wval = 3'h0;
  logic [3:0] fit = 4'h0, val = 4'h0, pins;
  logic       rsm_n, pg, mpd, spd, c48, seq_en, tmode;
  logic [7:0] idx, dat;
  logic [5:0] mhz;
  int         mismatches = 0, comparisons = 0, cycles = 0, n;

  always #2 sys_clk = ~sys_clk;

  slrg_board_model slrg_board_model_i (.sys_clk(sys_clk), .main_pulldown_en(mpd), .seq_pulldown_en(spd),
    .fit(fit), .val(val), .pins(pins));
  slrg_top #(.RSM_CYC(RSM), .PWR_CYC(PWR)) slrg_top_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .standby_rail_valid(sb_ok), .main_rail_valid(mn_ok), .supply_power_good_in(spg),
    .supply_pg_disable(spg_dis), .bus_reset_n(brst_n), .cfg_port_select_strap(pins[0]),
    .input_clock_rate_strap(pins[1]), .power_sequence_enable_strap(pins[2]), .factory_test_strap(pins[3]),
    .host_wr_en(wen), .host_wr_val(wval), .standby_resume_reset_n(rsm_n), .main_power_good(pg),
    .main_pulldown_en(mpd), .seq_pulldown_en(spd), .cfg_index_port(idx), .cfg_data_port(dat),
    .clock_is_48mhz(c48), .input_clock_mhz(mhz), .power_sequence_en(seq_en), .test_mode(tmode));

  task w(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : w

  task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", s, exp, seen);
    end
  endtask : chk

  // One-cycle host override, then room for the two register stages
  task hw(input int b, input logic v);
    wen[b] = 1'b1;
    wval[b] = v;
    w(1);
    wen = 3'h0;
    w(2);
  endtask : hw

  task t_reset;
    chk("rsm_n", rsm_n, 8'h00);
    chk("pg", pg, 8'h00);
    chk("mpd", mpd, 8'h01);
    chk("spd", spd, 8'h01);
    chk("pins", pins, 8'h00);
    chk("idx", idx, CFG_INDEX_LO);
    chk("mhz", mhz, 8'(CLK_RATE_LO_MHZ));
  endtask : t_reset

  task t_port;
    fit[0] = 1'b1;
    val[0] = 1'b1;
    hw(0, 1'b0);
    chk("idx", idx, CFG_INDEX_HI);
    brst_n = 1'b1;
    val[0] = 1'b0;
    w(3);
    chk("idx", idx, CFG_INDEX_HI);
    chk("dat", dat, CFG_DATA_HI);
    hw(0, 1'b0);
    chk("idx", idx, CFG_INDEX_LO);
    chk("dat", dat, CFG_DATA_LO);
    val[0] = 1'b1;
    brst_n = 1'b0;
    w(3);
    chk("idx", idx, CFG_INDEX_HI);
    brst_n = 1'b1;
  endtask : t_port

  // Release comes RSM_CYC edges after the rail turns valid
  task t_standby;
    fit[2] = 1'b1;
    val[2] = 1'b1;
    sb_ok = 1'b1;
    n = 0;
    while (rsm_n !== 1'b1 && n < 100) begin
      w(1);
      n++;
    end
    chk("rsm_dly", 8'(n), 8'(RSM));
    chk("spd", spd, 8'h00);
    w(2);
    chk("seq_en", seq_en, 8'h01);
    val[2] = 1'b0;
    w(3);
    chk("seq_en", seq_en, 8'h01);
    hw(2, 1'b0);
    chk("seq_en", seq_en, 8'h00);
    val[2] = 1'b1;
  endtask : t_standby

  task t_main;
    fit[1] = 1'b1;
    val[1] = 1'b1;
    fit[3] = 1'b1;
    val[3] = 1'b1;
    mn_ok = 1'b1;
    w(PWR + 5);
    chk("pg", pg, 8'h00);
    mn_ok = 1'b0;
    spg = 1'b1;
    w(2);
    mn_ok = 1'b1;
    n = 0;
    while (pg !== 1'b1 && n < 100) begin
      w(1);
      n++;
    end
    chk("pg_dly", 8'(n), 8'(PWR));
    chk("c48", c48, 8'h01);
    chk("mhz", mhz, 8'(CLK_RATE_HI_MHZ));
    chk("tmode", tmode, 8'h01);
    chk("mpd", mpd, 8'h00);
    val[3] = 1'b0;
    hw(1, 1'b0);
    chk("mhz", mhz, 8'(CLK_RATE_LO_MHZ));
    chk("tmode", tmode, 8'h01);
    mn_ok = 1'b0;
    w(3);
    chk("pg", pg, 8'h00);
    chk("mpd", mpd, 8'h01);
    chk("mhz", mhz, 8'(CLK_RATE_HI_MHZ));
    chk("tmode", tmode, 8'h00);
    spg = 1'b0;
    spg_dis = 1'b1;
    mn_ok = 1'b1;
    w(PWR + 5);
    chk("pg", pg, 8'h01);
  endtask : t_main

  task t_drop;
    sb_ok = 1'b0;
    w(1);
    chk("rsm_n", rsm_n, 8'h00);
    w(2);
    chk("spd", spd, 8'h01);
    chk("seq_en", seq_en, 8'h01);
  endtask : t_drop

  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // Whole run needs about 155 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_sim;
    end
  end

  initial begin
    w(3);
    rst_n = 1'b1;
    w(1);
    t_reset;
    t_port;
    t_standby;
    t_main;
    t_drop;
    end_sim;
  end
endmodule : strap_latch_reset_glue_tb_top
`default_nettype wire
